/* inc/cdcfm_pkg.sv */
package cdcfm_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_EXCITATION_SETUP_REG = 8'h09;
    localparam logic [7:0] ADDR_CONV_SETUP = 8'h0a;
    localparam logic [7:0] RST_EXCITATION_SETUP_REG = 8'h03;
    localparam logic [7:0] RST_CONV_SETUP = 8'ha0;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int VTF_HI = 7;
    localparam int VTF_LO = 6;
    localparam int CAPF_HI = 5;
    localparam int CAPF_LO = 3;
    localparam int MODE_HI = 2;
    localparam int MODE_LO = 0;
    localparam int CLK_HALVING_BIT = 7;
    localparam int STAT_CAP_BUSY_BIT = 0;
    localparam int STAT_VT_BUSY_BIT = 1;
    localparam int STAT_PENDING_BIT = 2;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_FREQ_HZ = 100000000;
    // Conversion times are held in tenths of a millisecond.
    localparam int TENTHS_PER_SEC = 10000;
    localparam int CYC_PER_TENTH_MS = CLK_FREQ_HZ / TENTHS_PER_SEC;
    localparam int MOD_DIV = 4;
    localparam int TENTHS_W = 12;

    // ****************************************************************
    // Modes
    // ****************************************************************
    typedef enum logic [2:0] {
        CDCFM_IDLE = 3'b000,
        CDCFM_CONT = 3'b001,
        CDCFM_SINGLE = 3'b010,
        CDCFM_PWRDN = 3'b011,
        CDCFM_RSVD = 3'b100,
        CDCFM_CAP_OFFS_CAL = 3'b101,
        CDCFM_GAIN_CAL = 3'b110,
        CDCFM_RSVD2 = 3'b111
    } cdcfm_mode_t;

    // Voltage/temperature conversion times, chopping on, normal clock.
    localparam logic [TENTHS_W-1:0] VT_T0 = 12'd201;
    localparam logic [TENTHS_W-1:0] VT_T1 = 12'd321;
    localparam logic [TENTHS_W-1:0] VT_T2 = 12'd621;
    localparam logic [TENTHS_W-1:0] VT_T3 = 12'd1221;
    // Capacitance conversion times, chopping off, normal clock.
    localparam logic [TENTHS_W-1:0] CAP_T0 = 12'd110;
    localparam logic [TENTHS_W-1:0] CAP_T1 = 12'd119;
    localparam logic [TENTHS_W-1:0] CAP_T2 = 12'd200;
    localparam logic [TENTHS_W-1:0] CAP_T3 = 12'd380;
    localparam logic [TENTHS_W-1:0] CAP_T4 = 12'd620;
    localparam logic [TENTHS_W-1:0] CAP_T5 = 12'd770;
    localparam logic [TENTHS_W-1:0] CAP_T6 = 12'd920;
    localparam logic [TENTHS_W-1:0] CAP_T7 = 12'd1096;

    function automatic logic [TENTHS_W-1:0] vt_tenths(input logic [1:0] code);
        unique case (code)
            2'h0: vt_tenths = VT_T0;
            2'h1: vt_tenths = VT_T1;
            2'h2: vt_tenths = VT_T2;
            2'h3: vt_tenths = VT_T3;
        endcase
    endfunction : vt_tenths

    function automatic logic [TENTHS_W-1:0] cap_tenths(input logic [2:0] code);
        unique case (code)
            3'h0: cap_tenths = CAP_T0;
            3'h1: cap_tenths = CAP_T1;
            3'h2: cap_tenths = CAP_T2;
            3'h3: cap_tenths = CAP_T3;
            3'h4: cap_tenths = CAP_T4;
            3'h5: cap_tenths = CAP_T5;
            3'h6: cap_tenths = CAP_T6;
            3'h7: cap_tenths = CAP_T7;
        endcase
    endfunction : cap_tenths

endpackage : cdcfm_pkg

/* verilog/cdcfm_conv_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module cdcfm_conv_timer #(
    parameter int CYC_PER_TENTH = cdcfm_pkg::CYC_PER_TENTH_MS,
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic start_en_i,
    input wire logic [cdcfm_pkg::TENTHS_W-1:0] tenths_i,
    input wire logic halve_i,
    // Status
    output logic busy_o,
    output logic done_o
);
    import cdcfm_pkg::*;

    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [CNT_W-1:0] base_cnt;

    // Settings are sampled only when a conversion starts, so a rewrite of
    // the filter code never stretches or cuts the running conversion.
    assign base_cnt = CNT_W'(tenths_i) * CNT_W'(CYC_PER_TENTH);

    always_comb begin
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        cnt_nxt = cnt_r;
        if (!busy_r) begin
            if (start_en_i) begin
                busy_nxt = 1'b1;
                cnt_nxt = halve_i ? (base_cnt << 1) : base_cnt;
            end
        end else if (cnt_r == CNT_W'(1)) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign busy_o = busy_r;
    assign done_o = done_r;

endmodule : cdcfm_conv_timer

`default_nettype wire

/* verilog/cdcfm_top.sv */
// What this block does
// - The converter setup register sits at address 0x0a and resets to 0xa0.
// - It holds a 2-bit volt/temp filter select in bits 7:6, a 3-bit cap filter in 5:3, mode in 2:0.
// - Volt/temp codes 0..3 give 20.1, 32.1, 62.1 and 122.1 ms conversions.
// - Cap codes 0..5 give 11.0, 11.9, 20.0, 38.0, 62.0 and 77.0 ms conversions.
// - With clock halving set, every selected conversion time is doubled.
// - Clock halving (bit 7 of the excitation register at 0x09) halves excitation and modulator rates.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module cdcfm_top #(
    parameter int CYC_PER_TENTH = cdcfm_pkg::CYC_PER_TENTH_MS,
    parameter int MOD_DIV = cdcfm_pkg::MOD_DIV
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Converter timing
    output logic cap_done_o,
    output logic vt_done_o,
    output logic mod_clk_en_o,
    output logic exc_clk_o,
    output logic [2:0] conv_mode_o
);
    import cdcfm_pkg::*;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] conv_setup_r, conv_setup_nxt;
    logic [7:0] excitation_setup_reg_r, excitation_setup_reg_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic cap_pend_r, cap_pend_nxt;
    logic vt_pend_r, vt_pend_nxt;
    logic cap_busy, vt_busy, cap_done, vt_done;
    logic cap_start, vt_start, continuous, one_shot;
    logic clock_halving;
    cdcfm_mode_t mode;

    assign mode = cdcfm_mode_t'(conv_setup_r[MODE_HI:MODE_LO]);
    assign clock_halving = excitation_setup_reg_r[CLK_HALVING_BIT];
    assign continuous = (mode == CDCFM_CONT);

    always_comb begin
        unique case (wdata_i[MODE_HI:MODE_LO])
            CDCFM_SINGLE, CDCFM_CAP_OFFS_CAL, CDCFM_GAIN_CAL: one_shot = 1'b1;
            default: one_shot = 1'b0;
        endcase
    end

    always_comb begin
        conv_setup_nxt = conv_setup_r;
        excitation_setup_reg_nxt = excitation_setup_reg_r;
        cap_pend_nxt = cap_pend_r && !cap_done;
        vt_pend_nxt = vt_pend_r && !vt_done;
        // A one-shot mode falls back to idle once every armed channel finishes.
        if ((cap_pend_r || vt_pend_r) && !cap_pend_nxt && !vt_pend_nxt) begin
            conv_setup_nxt[MODE_HI:MODE_LO] = CDCFM_IDLE;
        end
        // Software writes win over the return to idle.
        if (wr_i && addr_i == ADDR_CONV_SETUP) begin
            conv_setup_nxt = wdata_i;
            cap_pend_nxt = one_shot;
            vt_pend_nxt = one_shot && (wdata_i[MODE_HI:MODE_LO] == CDCFM_SINGLE);
        end
        if (wr_i && addr_i == ADDR_EXCITATION_SETUP_REG) begin
            excitation_setup_reg_nxt = wdata_i;
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                ADDR_CONV_SETUP: rdata_nxt = conv_setup_r;
                ADDR_EXCITATION_SETUP_REG: rdata_nxt = excitation_setup_reg_r;
                ADDR_STATUS: begin
                    rdata_nxt[STAT_CAP_BUSY_BIT] = cap_busy;
                    rdata_nxt[STAT_VT_BUSY_BIT] = vt_busy;
                    rdata_nxt[STAT_PENDING_BIT] = cap_pend_r || vt_pend_r;
                end
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            conv_setup_r <= RST_CONV_SETUP;
            excitation_setup_reg_r <= RST_EXCITATION_SETUP_REG;
            rdata_r <= 8'h00;
            cap_pend_r <= 1'b0;
            vt_pend_r <= 1'b0;
        end else begin
            conv_setup_r <= conv_setup_nxt;
            excitation_setup_reg_r <= excitation_setup_reg_nxt;
            rdata_r <= rdata_nxt;
            cap_pend_r <= cap_pend_nxt;
            vt_pend_r <= vt_pend_nxt;
        end
    end

    // ****************************************************************
    // Conversion timers
    // ****************************************************************
    // The done term blocks a restart in the cycle where the pending flag
    // of a one-shot mode is still being cleared.
    assign cap_start = (continuous || cap_pend_r) && !cap_done;
    assign vt_start = (continuous || vt_pend_r) && !vt_done;

    cdcfm_conv_timer #(
        .CYC_PER_TENTH(CYC_PER_TENTH),
        .CNT_W(32)
    ) u_cap_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_en_i(cap_start),
        .tenths_i(cap_tenths(conv_setup_r[CAPF_HI:CAPF_LO])),
        .halve_i(clock_halving),
        .busy_o(cap_busy),
        .done_o(cap_done)
    );

    cdcfm_conv_timer #(
        .CYC_PER_TENTH(CYC_PER_TENTH),
        .CNT_W(32)
    ) u_vt_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_en_i(vt_start),
        .tenths_i(vt_tenths(conv_setup_r[VTF_HI:VTF_LO])),
        .halve_i(clock_halving),
        .busy_o(vt_busy),
        .done_o(vt_done)
    );

    // ****************************************************************
    // Modulator and excitation rate
    // ****************************************************************
    logic [15:0] div_r, div_nxt;
    logic mod_en_r, mod_en_nxt;
    logic exc_r, exc_nxt;
    logic [15:0] div_last;

    assign div_last = clock_halving ? 16'(2 * MOD_DIV - 1) : 16'(MOD_DIV - 1);

    always_comb begin
        div_nxt = div_r + 16'h0001;
        mod_en_nxt = 1'b0;
        exc_nxt = exc_r;
        if (mode == CDCFM_PWRDN) begin
            div_nxt = 16'h0000;
        end else if (div_r >= div_last) begin
            div_nxt = 16'h0000;
            mod_en_nxt = 1'b1;
            exc_nxt = !exc_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_r <= 16'h0000;
            mod_en_r <= 1'b0;
            exc_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            mod_en_r <= mod_en_nxt;
            exc_r <= exc_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign cap_done_o = cap_done;
    assign vt_done_o = vt_done;
    assign mod_clk_en_o = mod_en_r;
    assign exc_clk_o = exc_r;
    assign conv_mode_o = conv_setup_r[MODE_HI:MODE_LO];

endmodule : cdcfm_top

`default_nettype wire

/* tb/cdcfm_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module cdcfm_checker #(
    parameter int CYC_PER_TENTH = 1,
    parameter int MOD_DIV = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Converter timing
    input wire logic cap_done_o,
    input wire logic vt_done_o,
    input wire logic mod_clk_en_o,
    input wire logic exc_clk_o,
    input wire logic [2:0] conv_mode_o
);
    logic [2:0] wr_mode;

    // The mode field is split off as a plain signal so that $past sees a signal.
    assign wr_mode = wdata_i[2:0];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_rd_idle;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    property p_rd_back;
        (wr_i && addr_i == 8'h0a) ##1 (rd_i && addr_i == 8'h0a) |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_rd_back: assert property (p_rd_back) else $error("setup readback wrong");
    property p_rd_unmapped;
        rd_i && addr_i == 8'h55 |=> rdata_o == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
    property p_mode_write;
        wr_i && addr_i == 8'h0a |=> conv_mode_o == $past(wr_mode);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode not updated");
    property p_cap_gap;
        cap_done_o |=> !cap_done_o [*8];
    endproperty
    a_cap_gap: assert property (p_cap_gap) else $error("cap done too soon");
    property p_vt_gap;
        vt_done_o |=> !vt_done_o [*8];
    endproperty
    a_vt_gap: assert property (p_vt_gap) else $error("vt done too soon");
    property p_mod_gap;
        mod_clk_en_o |=> !mod_clk_en_o [*3];
    endproperty
    a_mod_gap: assert property (p_mod_gap) else $error("modulator pulses too close");
    property p_exc_follow;
        $changed(exc_clk_o) |-> (mod_clk_en_o || $past(mod_clk_en_o));
    endproperty
    a_exc_follow: assert property (p_exc_follow) else $error("excitation moved alone");
endmodule : cdcfm_checker

bind cdcfm_top cdcfm_checker #(.CYC_PER_TENTH(CYC_PER_TENTH), .MOD_DIV(MOD_DIV)) cdcfm_checker_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .cap_done_o(cap_done_o), .vt_done_o(vt_done_o),
    .mod_clk_en_o(mod_clk_en_o), .exc_clk_o(exc_clk_o), .conv_mode_o(conv_mode_o));

`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int MD = 4;
    logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0;
    logic [7:0] addr_i = 0, wdata_i = 0, rdata_o;
    logic cap_done_o, vt_done_o, mod_clk_en_o, exc_clk_o;
    logic [2:0] conv_mode_o;
    int n_errors = 0, compares = 0, n;
    int vt_t[4] = '{201, 321, 621, 1221};
    int cap_t[6] = '{110, 119, 200, 380, 620, 770};
    always #5 clk_i = ~clk_i;
    // One tenth of a millisecond shrinks to a single cycle to keep the run short.
    cdcfm_top #(.CYC_PER_TENTH(1), .MOD_DIV(MD)) cdcfm_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cap_done_o(cap_done_o), .vt_done_o(vt_done_o), .mod_clk_en_o(mod_clk_en_o),
        .exc_clk_o(exc_clk_o), .conv_mode_o(conv_mode_o));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= d;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1, 0, a, d);
        bus(0, 0, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(0, 1, a, 8'h00);
        bus(0, 0, a, 8'h00);
        #1 check(rdata_o, exp);
    endtask : rd
    function automatic logic ev(input int w);
        return (w == 0) ? cap_done_o : ((w == 1) ? vt_done_o : mod_clk_en_o);
    endfunction : ev
    // Counts cycles up to the next event; earlier loops only align to an event.
    task automatic meas(input int w, input int skip, output int k);
        repeat (skip + 1) begin
            k = 0;
            do begin
                @(posedge clk_i);
                #1 k++;
            end while (!ev(w) && k < 4000);
        end
    endtask : meas
    task automatic report_and_stop;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        rd(8'h0a, 8'ha0);
        rd(8'h09, 8'h03);
        check(conv_mode_o, 16'h0);
        bus(1, 0, 8'h0a, 8'h7b);
        bus(0, 1, 8'h0a, 8'h00);
        bus(0, 0, 8'h0a, 8'h00);
        #1 check(rdata_o, 8'h7b);
        check(conv_mode_o, 16'h3);
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        $display("t_reset end");
    endtask : t_reset
    task automatic t_rates;
        logic e;
        for (int i = 0; i < 4; i++) begin
            wr(8'h0a, {i[1:0], 3'b000, 3'b001});
            meas(1, 2, n);
            check(n, vt_t[i] + 2);
        end
        for (int i = 0; i < 6; i++) begin
            wr(8'h0a, {2'b00, i[2:0], 3'b001});
            meas(0, 2, n);
            check(n, cap_t[i] + 2);
        end
        meas(2, 1, n);
        check(n, MD);
        e = exc_clk_o;
        meas(2, 0, n);
        check(exc_clk_o, !e);
        check(n, MD);
        $display("t_rates end");
    endtask : t_rates
    task automatic t_halve;
        wr(8'h09, 8'h83);
        meas(2, 1, n);
        check(n, 2 * MD);
        wr(8'h0a, 8'h01);
        meas(1, 2, n);
        check(n, 2 * vt_t[0] + 2);
        meas(0, 1, n);
        check(n, 2 * cap_t[0] + 2);
        @(posedge clk_i) rst_n_i <= 0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1;
        rd(8'h09, 8'h03);
        $display("t_halve end");
    endtask : t_halve
    task automatic t_defer;
        wr(8'h0a, {2'b00, 3'd5, 3'b001});
        meas(0, 2, n);
        wr(8'h0a, 8'h01);
        meas(0, 0, n);
        check(n + 2, cap_t[5] + 2);
        meas(0, 0, n);
        check(n, cap_t[0] + 2);
        $display("t_defer end");
    endtask : t_defer
    task automatic t_single;
        wr(8'h0a, 8'h00);
        repeat (500) @(posedge clk_i);
        wr(8'h0a, 8'h02);
        meas(1, 0, n);
        check(n, vt_t[0] + 1);
        @(posedge clk_i);
        #1 check(conv_mode_o, 16'h0);
        // A calibration mode arms only the capacitance channel.
        wr(8'h0a, 8'h05);
        meas(0, 0, n);
        check(n, cap_t[0] + 1);
        @(posedge clk_i);
        #1 check(conv_mode_o, 16'h0);
        $display("t_single end");
    endtask : t_single
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1;
        t_reset();
        t_rates();
        t_halve();
        t_defer();
        t_single();
        report_and_stop();
    end
    initial begin
        #1000000;
        n_errors++;
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
